// ### msr_core.sv
// Purpose: Status byte, signals word and position reports to the host
// Assumes: Host pins synchronous; event inputs are one-cycle pulses
// Notes:   Profile, filter and encoder logic sit outside this block
`timescale 1ns/1ps
`include "msr_params.svh"

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Status byte read anytime, no command needed
// - Bit 7 flags motor off at zero drive
// - Motor-off stop applies at start; else cleared
// - Bit 6 breakpoint passed, sticky until clear
// - Bit 5 excessive position error, sticky
// - Bit 4 position wraparound, sticky
// - Bit 3 index captured while armed, sticky
// - Bit 2 set when (on-target OR motor off) goes from false to true, sticky
// - Bit 1 wrong transfer direction, sticky
// - Writes while busy are discarded
// - Busy reads return buffer, no error
// - Signals word read as two bytes, high first
// - Signals low byte mirrors status; bit0 index arm
// - Unmasked events raise interrupt pin and bit 15
// - Bit 14 acceleration loaded, cleared at start
// - Bit 13 filter update, cleared at interval end
// - Bit 12 direction taken at start
// - Bit 11 velocity mode taken at start
// - Bit 10 on target, cleared at start
// - Bit 9 stop-on-error armed or disarmed
// - Bit 8 byte output mode, set at reset
// - Index and desired position: four bytes, high first
module msr_core #(
  parameter int BUSY_CYC = `MSR_BUSY_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        cs_n_i,
  input  wire logic        port_select_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  host_data_i,
  output logic      [7:0]  host_data_o,
  output logic             host_data_oe_n_o,
  output logic             host_irq_o,
  input  wire logic [5:0]  irq_enable_i,
  input  wire logic        breakpoint_hit_i,
  input  wire logic        pos_error_i,
  input  wire logic        wraparound_i,
  input  wire logic        index_pulse_i,
  input  wire logic        traj_done_i,
  input  wire logic        sample_end_i,
  input  wire logic [31:0] index_position_i,
  input  wire logic [31:0] desired_position_i,
  output logic             motor_off_o,
  output logic             velocity_mode_o,
  output logic             forward_dir_o,
  output logic             eight_bit_out_o,
  output logic             stop_on_error_o
);
  ////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////
  msr_pkg::msr_core_st_t st_ff;        // Registered state
  msr_pkg::msr_core_st_t nxt_st;       // Next state
  logic                  cmd_wr;       // Command write ended
  logic                  data_wr;      // Data write ended
  logic                  data_rd;      // Data read ended
  logic [7:0]            wr_data;      // Byte of last write
  logic                  busy;         // Busy status bit
  logic [5:0]            flags;        // Sticky flags, status 6..1
  logic                  irq;          // Host interrupt level
  logic [5:0]            flag_set;     // Flag set pulses
  logic                  flag_clr;     // Clear-interrupts pulse
  logic [7:0]            status_byte;  // Status byte view
  logic [15:0]           signals_word; // Signals register view
  logic                  err;          // Direction error pulse
  logic                  done_now;     // Completion term, now
  logic                  done_nxt;     // Completion term, next

  localparam logic [`MSR_BUSY_W-1:0] BUSY_LOAD =
    `MSR_BUSY_W'(BUSY_CYC);

  localparam msr_pkg::msr_core_st_t RST_ST = '{
    phase:       msr_pkg::MSR_PH_IDLE,
    busy_cnt:    '0,
    bytes_left:  `MSR_LEN_NONE,
    tw_hdr:      1'b0,
    first_param: 1'b0,
    traj_pend:   16'h0000,
    shift:       32'h0000_0000,
    motor_off:   1'b1,
    on_target:   1'b0,
    vel:         1'b0,
    fwd:         1'b0,
    filt_upd:    1'b0,
    stop_arm:    1'b0,
    out8:        1'b1,
    idx_arm:     1'b0,
    acc_ld:      1'b0,
    dout:        8'h00
  };

  ////////////////////////////////////////////////////////////////////
  // Command table
  ////////////////////////////////////////////////////////////////////
  // Bytes that follow a command on the data port
  function automatic logic [3:0] cmd_len(input logic [7:0] code);
    logic [3:0] len;
    len = `MSR_LEN_NONE;
    unique case (code)
      `MSR_CMD_SIGS:                len = `MSR_LEN_WORD;
      `MSR_CMD_IDX, `MSR_CMD_DP:    len = `MSR_LEN_LONG;
      `MSR_CMD_ERR_STOP, `MSR_CMD_ERR_IRQ: len = `MSR_LEN_WORD;
      `MSR_CMD_BP_ABS, `MSR_CMD_BP_REL:    len = `MSR_LEN_LONG;
      `MSR_CMD_TRAJ:                       len = `MSR_LEN_WORD;
      default:                      len = `MSR_LEN_NONE;
    endcase
    return len;
  endfunction

  // Whether a command is a report the host reads
  function automatic logic cmd_is_read(input logic [7:0] code);
    return (code == `MSR_CMD_SIGS) || (code == `MSR_CMD_IDX) ||
           (code == `MSR_CMD_DP);
  endfunction

  // Parameter bytes announced by a trajectory control word
  function automatic logic [3:0] tw_len(input logic [15:0] tw);
    logic [3:0] len;
    len = `MSR_LEN_NONE;
    if (tw[`MSR_TW_ACC]) len = len + `MSR_LEN_LONG;
    if (tw[`MSR_TW_VLD]) len = len + `MSR_LEN_LONG;
    if (tw[`MSR_TW_PLD]) len = len + `MSR_LEN_LONG;
    return len;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Submodules
  ////////////////////////////////////////////////////////////////////
  // Strobe end detection on the host port
  msr_strobe u_strobe (
    .clk_sys_i       (clk_sys_i),
    .resetn_i        (resetn_i),
    .cs_n_i          (cs_n_i),
    .port_select_n_i (port_select_n_i),
    .rd_n_i          (rd_n_i),
    .wr_n_i          (wr_n_i),
    .host_data_i     (host_data_i),
    .cmd_wr_o        (cmd_wr),
    .data_wr_o       (data_wr),
    .data_rd_o       (data_rd),
    .wr_data_o       (wr_data)
  );

  // Sticky interrupt flags and host pin
  msr_flags #(
    .NUM (6)
  ) u_flags (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .set_i     (flag_set),
    .enable_i  (irq_enable_i),
    .clear_i   (flag_clr),
    .flags_o   (flags),
    .irq_o     (irq)
  );

  ////////////////////////////////////////////////////////////////////
  // Register views
  ////////////////////////////////////////////////////////////////////
  assign busy = (st_ff.busy_cnt != '0);

  // Status byte: motor off, six flags, busy
  assign status_byte = {st_ff.motor_off, flags, busy};

  // Signals word: mode flags over a mirror of the status byte
  assign signals_word = {irq, st_ff.acc_ld, st_ff.filt_upd,
                         st_ff.fwd, st_ff.vel,
                         st_ff.on_target, st_ff.stop_arm,
                         st_ff.out8,
                         status_byte[7:1], st_ff.idx_arm};

  // Completion term, now and after this cycle
  assign done_now = st_ff.motor_off | st_ff.on_target;
  assign done_nxt = nxt_st.motor_off | nxt_st.on_target;

  // Event pulses into the sticky flags
  assign flag_set = {breakpoint_hit_i,
                     pos_error_i,
                     wraparound_i,
                     index_pulse_i & st_ff.idx_arm,
                     done_nxt & ~done_now,
                     err};

  // Clear-interrupts command, only when not busy
  assign flag_clr = cmd_wr & ~busy &
                    (wr_data == `MSR_CMD_CLR_IRQ);

  ////////////////////////////////////////////////////////////////////
  // Host port data path
  ////////////////////////////////////////////////////////////////////
  // Drive the bus while selected and read strobe low
  assign host_data_oe_n_o = cs_n_i | rd_n_i;
  assign host_data_o      = st_ff.dout;
  assign host_irq_o       = irq;

  // Direction error: data transfer against the expected phase
  always_comb begin
    err = 1'b0;
    if (!busy) begin
      if (data_wr && st_ff.phase != msr_pkg::MSR_PH_WRITE) begin
        err = 1'b1;
      end
      if (data_rd && st_ff.phase != msr_pkg::MSR_PH_READ) begin
        err = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;

    // Busy countdown
    if (busy) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - 1'b1;
    end

    // Output byte: status on command port, buffer on data port
    if (!port_select_n_i) begin
      nxt_st.dout = status_byte;
    end else begin
      nxt_st.dout = st_ff.shift[31:24];
    end

    // Filter update flag ends with the sampling interval
    if (sample_end_i) begin
      nxt_st.filt_upd = 1'b0;
    end

    // Index pulse consumes the arm flag
    if (index_pulse_i && st_ff.idx_arm) begin
      nxt_st.idx_arm = 1'b0;
    end

    // Command write; ignored while busy
    if (cmd_wr && !busy) begin
      nxt_st.busy_cnt    = BUSY_LOAD;
      nxt_st.bytes_left  = cmd_len(wr_data);
      nxt_st.tw_hdr      = 1'b0;
      nxt_st.first_param = 1'b0;
      nxt_st.phase       = msr_pkg::MSR_PH_IDLE;
      if (cmd_len(wr_data) != `MSR_LEN_NONE) begin
        nxt_st.phase = cmd_is_read(wr_data) ?
                       msr_pkg::MSR_PH_READ : msr_pkg::MSR_PH_WRITE;
      end
      unique case (wr_data)
        `MSR_CMD_RESET: begin
          nxt_st.motor_off = 1'b1;
          nxt_st.out8      = 1'b1;
        end
        `MSR_CMD_START: begin
          // Start motion applies the pending trajectory word
          nxt_st.motor_off = st_ff.traj_pend[`MSR_TW_MOFF];
          nxt_st.vel       = st_ff.traj_pend[`MSR_TW_VEL];
          nxt_st.fwd       = st_ff.traj_pend[`MSR_TW_FWD];
          nxt_st.acc_ld    = 1'b0;
          nxt_st.on_target = 1'b0;
        end
        `MSR_CMD_SIGS:     nxt_st.shift = {signals_word, 16'h0000};
        `MSR_CMD_IDX:      nxt_st.shift = index_position_i;
        `MSR_CMD_DP:       nxt_st.shift = desired_position_i;
        `MSR_CMD_ERR_STOP: nxt_st.stop_arm = 1'b1;
        `MSR_CMD_ERR_IRQ:  nxt_st.stop_arm = 1'b0;
        `MSR_CMD_ARM_IDX:  nxt_st.idx_arm = 1'b1;
        `MSR_CMD_FILT:     nxt_st.filt_upd = 1'b1;
        `MSR_CMD_OUT8:     nxt_st.out8 = 1'b1;
        `MSR_CMD_OUT12:    nxt_st.out8 = 1'b0;
        `MSR_CMD_TRAJ:     nxt_st.tw_hdr = 1'b1;
        default: begin
          // Commands handled elsewhere, or flag clear only
        end
      endcase
    end

    // Data write into an expected write sequence
    if (data_wr && !busy &&
        st_ff.phase == msr_pkg::MSR_PH_WRITE) begin
      nxt_st.busy_cnt   = BUSY_LOAD;
      nxt_st.bytes_left = st_ff.bytes_left - 1'b1;
      if (st_ff.tw_hdr) begin
        // Trajectory control word, high byte first
        nxt_st.traj_pend = {st_ff.traj_pend[7:0], wr_data};
        if (st_ff.bytes_left == `MSR_LEN_ONE) begin
          nxt_st.tw_hdr      = 1'b0;
          nxt_st.first_param = 1'b1;
          nxt_st.bytes_left  = tw_len({st_ff.traj_pend[7:0], wr_data});
          if (tw_len({st_ff.traj_pend[7:0], wr_data}) ==
              `MSR_LEN_NONE) begin
            nxt_st.phase = msr_pkg::MSR_PH_IDLE;
          end
        end
      end else begin
        // Acceleration data is always the first parameter
        nxt_st.first_param = 1'b0;
        if (st_ff.first_param && st_ff.traj_pend[`MSR_TW_ACC]) begin
          nxt_st.acc_ld = 1'b1;
        end
        if (st_ff.bytes_left == `MSR_LEN_ONE) begin
          nxt_st.phase = msr_pkg::MSR_PH_IDLE;
        end
      end
    end

    // Data read from an expected report, most significant first
    if (data_rd && !busy &&
        st_ff.phase == msr_pkg::MSR_PH_READ) begin
      nxt_st.busy_cnt   = BUSY_LOAD;
      nxt_st.shift      = {st_ff.shift[23:0], 8'h00};
      nxt_st.bytes_left = st_ff.bytes_left - 1'b1;
      if (st_ff.bytes_left == `MSR_LEN_ONE) begin
        nxt_st.phase = msr_pkg::MSR_PH_IDLE;
      end
    end

    // Move finished; wins over a start in the same cycle
    if (traj_done_i) begin
      nxt_st.on_target = 1'b1;
    end

    // Excessive error turns the motor off when armed; wins over start
    if (pos_error_i && st_ff.stop_arm) begin
      nxt_st.motor_off = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register; status reads touch nothing here
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode outputs to the rest of the device
  ////////////////////////////////////////////////////////////////////
  assign motor_off_o     = st_ff.motor_off;
  assign velocity_mode_o = st_ff.vel;
  assign forward_dir_o   = st_ff.fwd;
  assign eight_bit_out_o = st_ff.out8;
  assign stop_on_error_o = st_ff.stop_arm;
endmodule

// ### msr_flags.sv
// Purpose: Six sticky interrupt flags and the host interrupt
// Assumes: Set and clear are one-cycle pulses
// Notes:   A set in the clearing cycle survives
`timescale 1ns/1ps
`include "msr_params.svh"
module msr_flags #(
  parameter int NUM = 6
) (
  input  wire logic           clk_sys_i,
  input  wire logic           resetn_i,
  input  wire logic [NUM-1:0] set_i,
  input  wire logic [NUM-1:0] enable_i,
  input  wire logic           clear_i,
  output logic [NUM-1:0]      flags_o,
  output logic                irq_o
);
  msr_pkg::msr_flag_st_t st_ff;
  msr_pkg::msr_flag_st_t nxt_st;
  logic [NUM-1:0]        nxt_flags;   // Next flag values
  logic [NUM-1:0]        unmasked;    // Events reaching the pin

  // Per flag: set wins over clear, mask never gates the flag
  for (genvar i = 0; i < NUM; i++) begin : g_flag
    assign nxt_flags[i] = set_i[i] | (st_ff.flags[i] & ~clear_i);
    assign unmasked[i]  = set_i[i] & enable_i[i];
  end

  // Assemble next state
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.flags = nxt_flags;
    nxt_st.irq   = (|unmasked) | (st_ff.irq & ~clear_i);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '{flags: `MSR_FLAGS_RST, irq: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flags_o = st_ff.flags;
  assign irq_o   = st_ff.irq;
endmodule

// ### msr_host.sv
// Purpose: Host processor model on the parallel port
// Assumes: Strobes start just after the rising clock edge
// Notes:   Released data bus shows the inverse of the last byte
`timescale 1ns/1ps
module msr_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            cs_n_o,
  output logic            port_sel_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [7:0]      wdata_o,
  output logic [7:0]      rbyte_o,
  output logic            got_o
);
  // Idle bus; no byte taken yet
  initial begin
    {cs_n_o, port_sel_n_o, rd_n_o, wr_n_o, wdata_o, rbyte_o} = '1;
    got_o = 1'b0;
  end
  // One write strobe, then a high cycle
  task automatic wr(input logic p, input logic [7:0] d);
    @(posedge clk_i);
    #1 {cs_n_o, port_sel_n_o, wr_n_o, wdata_o} = {1'b0, p, 1'b0, d};
    @(posedge clk_i);
    #1 {cs_n_o, wr_n_o, wdata_o} = {2'b11, ~d};
    @(posedge clk_i);
  endtask
  // Read strobe held two cycles, byte taken before release
  task automatic rd(input logic p, output logic [7:0] d, input logic n);
    @(posedge clk_i);
    #1 {cs_n_o, port_sel_n_o, rd_n_o, got_o} = {1'b0, p, 2'b00};
    repeat (2) @(posedge clk_i);
    #1 d = rdata_i;
    {rbyte_o, got_o, cs_n_o, rd_n_o} = {rdata_i, n, 2'b11};
    @(posedge clk_i);
    #1 got_o = 1'b0;
  endtask
  // Polls the status byte until busy drops
  task automatic wt();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 20 && s[0] === 1'b1; i++) rd(1'b0, s, 1'b0);
  endtask
endmodule

// ### msr_params.svh
// Purpose: Shared constants of the motion status reporting block
// Assumes: Included by every design file of the block
// Notes:   Definitions only
`ifndef MSR_PARAMS_SVH
`define MSR_PARAMS_SVH
// Command codes written to the command port
`define MSR_CMD_RESET   8'h00
`define MSR_CMD_START     8'h01
`define MSR_CMD_ARM_IDX   8'h03
`define MSR_CMD_FILT      8'h04
`define MSR_CMD_OUT8      8'h05
`define MSR_CMD_OUT12     8'h06
`define MSR_CMD_DP        8'h08
`define MSR_CMD_IDX       8'h09
`define MSR_CMD_SIGS      8'h0C
`define MSR_CMD_ERR_STOP  8'h1A
`define MSR_CMD_ERR_IRQ   8'h1B
`define MSR_CMD_CLR_IRQ   8'h1D
`define MSR_CMD_TRAJ      8'h1F
`define MSR_CMD_BP_ABS    8'h20
`define MSR_CMD_BP_REL    8'h21
// Trajectory control word bit positions
`define MSR_TW_FWD      12
`define MSR_TW_VEL      11
`define MSR_TW_MOFF     8
`define MSR_TW_ACC      5
`define MSR_TW_VLD      3
`define MSR_TW_PLD      1
// Byte counts of data transfers
`define MSR_LEN_NONE    4'h0
`define MSR_LEN_ONE     4'h1
`define MSR_LEN_WORD    4'h2
`define MSR_LEN_LONG    4'h4
// Reset values and timing
`define MSR_FLAGS_RST   6'h02
`define MSR_BUSY_CYC    4
`define MSR_BUSY_W      4
`endif

// ### msr_pkg.sv
// Purpose: Types of the motion status reporting block
// Assumes: msr_params.svh supplies the widths
// Notes:   State of each module is one packed struct
`include "msr_params.svh"
package msr_pkg;
  // Expected direction of the next data transfer
  typedef enum logic [1:0] {
    MSR_PH_IDLE,
    MSR_PH_READ,
    MSR_PH_WRITE
  } msr_phase_t;

  // Strobe front end state
  typedef struct packed {
    logic       rd_n_d;   // Read strobe, last cycle
    logic       wr_n_d;   // Write strobe, last cycle
    logic       sel;      // Chip selected during strobe
    logic       port_sel_n; // Port select during strobe
    logic [7:0] data;     // Write data seen during strobe
  } msr_strb_st_t;

  // Sticky flag state
  typedef struct packed {
    logic [5:0] flags;    // Six interrupt flags
    logic       irq;      // Host interrupt level
  } msr_flag_st_t;

  // Core state
  typedef struct packed {
    msr_phase_t             phase;
    logic [`MSR_BUSY_W-1:0] busy_cnt;
    logic [3:0]             bytes_left;
    logic                   tw_hdr;
    logic                   first_param;
    logic [15:0]            traj_pend;
    logic [31:0]            shift;
    logic                   motor_off;
    logic                   on_target;
    logic                   vel;
    logic                   fwd;
    logic                   filt_upd;
    logic                   stop_arm;
    logic                   out8;
    logic                   idx_arm;
    logic                   acc_ld;
    logic [7:0]             dout;
  } msr_core_st_t;
endpackage

// ### msr_strobe.sv
// Purpose: Detects the end of host read and write strobes
// Assumes: Host pins synchronous to clk_sys_i
// Notes:   Pulses fire in the same cycle in which a strobe rises
`timescale 1ns/1ps
`include "msr_params.svh"
module msr_strobe (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic       cs_n_i,
  input  wire logic       port_select_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] host_data_i,
  output logic            cmd_wr_o,
  output logic            data_wr_o,
  output logic            data_rd_o,
  output logic [7:0]      wr_data_o
);
  msr_pkg::msr_strb_st_t st_ff;
  msr_pkg::msr_strb_st_t nxt_st;
  logic                  rd_end;   // Read strobe just rose
  logic                  wr_end;   // Write strobe just rose

  assign rd_end    = rd_n_i & ~st_ff.rd_n_d;
  assign wr_end    = wr_n_i & ~st_ff.wr_n_d;
  assign cmd_wr_o  = wr_end & st_ff.sel & ~st_ff.port_sel_n;
  assign data_wr_o = wr_end & st_ff.sel & st_ff.port_sel_n;
  assign data_rd_o = rd_end & st_ff.sel & st_ff.port_sel_n;
  assign wr_data_o = st_ff.data;

  // Capture select while a strobe is low, data while selected and write is low
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rd_n_d = rd_n_i;
    nxt_st.wr_n_d = wr_n_i;
    if (!rd_n_i || !wr_n_i) begin
      nxt_st.sel  = ~cs_n_i;
      nxt_st.port_sel_n = port_select_n_i;
    end
    if (!wr_n_i && !cs_n_i) begin
      nxt_st.data = host_data_i;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '{rd_n_d: 1'b1, wr_n_d: 1'b1, sel: 1'b0, port_sel_n: 1'b0,
                 data: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ### msr_sva.sv
// Purpose: Port assertions for the status reporting block
// Assumes: Bound to msr_core; one clock domain
// Notes:   wtk marks the cycle in which a write take can show
`timescale 1ns/1ps
module msr_sva #(
  parameter int BUSY_CYC = 4
) (
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic       cs_n_i,
  input wire logic       port_select_n_i,
  input wire logic       rd_n_i,
  input wire logic       wr_n_i,
  input wire logic [7:0] host_data_o,
  input wire logic       host_data_oe_n_o,
  input wire logic       host_irq_o,
  input wire logic [5:0] irq_enable_i,
  input wire logic       breakpoint_hit_i,
  input wire logic       pos_error_i,
  input wire logic       wraparound_i,
  input wire logic       motor_off_o,
  input wire logic       velocity_mode_o,
  input wire logic       forward_dir_o,
  input wire logic       eight_bit_out_o,
  input wire logic       stop_on_error_o
);
  ////////////////////////////////////////////////////////////////////
  logic [1:0] wr_hist_ff;  // Write strobe, last two cycles
  logic       wtk;         // Output may move after a write take
  // Strobe history shift
  always_ff @(posedge clk_sys_i) wr_hist_ff <= {wr_hist_ff[0], wr_n_i};
  assign wtk = wr_hist_ff[0] & ~wr_hist_ff[1];
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////
  property p_oe; host_data_oe_n_o == (cs_n_i | rd_n_i); endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong");
  property p_irq_set; breakpoint_hit_i && irq_enable_i[5] || pos_error_i
    && irq_enable_i[4] || wraparound_i && irq_enable_i[3] |=> host_irq_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq missed");
  property p_irq_hold;
    host_irq_o && wr_n_i && wr_hist_ff[1:0] == 2'b11 |=> host_irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
  property p_stat7; !cs_n_i && !rd_n_i && $past(resetn_i) &&
    $past(!port_select_n_i) |-> host_data_o[7] == $past(motor_off_o);
  endproperty
  a_stat7: assert property (p_stat7) else $error("status bit7");
  property p_modes;
    $changed(velocity_mode_o) || $changed(forward_dir_o) |-> wtk;
  endproperty
  a_modes: assert property (p_modes) else $error("mode moved");
  property p_outsel;
    $changed(eight_bit_out_o) || $changed(stop_on_error_o) |-> wtk;
  endproperty
  a_outsel: assert property (p_outsel) else $error("sel moved");
  property p_mfall; $fell(motor_off_o) |-> wtk; endproperty
  a_mfall: assert property (p_mfall) else $error("motor on");
  property p_mrise; $rose(motor_off_o) |->
    wtk || $past(pos_error_i) && $past(stop_on_error_o); endproperty
  a_mrise: assert property (p_mrise) else $error("motor off");
  c_irq: cover property ($rose(host_irq_o));
  c_mfall: cover property ($fell(motor_off_o));
  c_vel: cover property ($rose(velocity_mode_o));
endmodule

bind msr_core msr_sva #(.BUSY_CYC(BUSY_CYC)) msr_sva_i (.*);

// ### tb.sv
// Purpose: Self-checking bench for the status reporting block
// Assumes: Host model drives the port; expected bytes noted in a queue
// Notes:   Events pulse for one cycle from ev
`timescale 1ns/1ps
module tb;
  logic       clk_sys_i, resetn_i, got, cs_n, port_sel_n, rd_n, wr_n;
  logic [7:0] hd, wd, rb, v, e;
  logic [5:0] en;
  logic [6:1] ev;
  logic [31:0] seed, ip, dp;
  logic [7:0] q[$];
  logic [7:0] mc[5] = '{8'h1A, 8'h1B, 8'h06, 8'h05, 8'h04};
  logic [7:0] mh[5] = '{8'h03, 8'h01, 8'h00, 8'h01, 8'h21};
  int         fail_count, samples_checked;
  msr_core msr_core_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .cs_n_i(cs_n), .port_select_n_i(port_sel_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .host_data_i(wd), .host_data_o(hd), .host_data_oe_n_o(),
    .host_irq_o(), .irq_enable_i(en), .breakpoint_hit_i(ev[6]),
    .pos_error_i(ev[5]), .wraparound_i(ev[4]), .index_pulse_i(ev[3]),
    .traj_done_i(ev[2]), .sample_end_i(ev[1]), .index_position_i(ip),
    .desired_position_i(dp), .motor_off_o(), .velocity_mode_o(),
    .forward_dir_o(), .eight_bit_out_o(), .stop_on_error_o());
  msr_host msr_host_i (.clk_i(clk_sys_i), .rdata_i(hd), .cs_n_o(cs_n),
    .port_sel_n_o(port_sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .wdata_o(wd),
    .rbyte_o(rb), .got_o(got));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic put(input logic p, input logic [7:0] d);
    msr_host_i.wr(p, d);
    msr_host_i.wt();
  endtask
  task automatic chk(input logic p, input logic [7:0] x);
    q.push_back(x);
    msr_host_i.rd(p, v, 1'b1);
    if (p) msr_host_i.wt();
  endtask
  task automatic sig(input logic [7:0] h, input logic [7:0] l);
    put(1'b0, 8'h0C);
    chk(1'b1, h);
    chk(1'b1, l);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_sys_i);
    #1 ev[b] = 1'b1;
    @(posedge clk_sys_i);
    #1 ev = '0;
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compares each byte taken with the oldest note
  always @(posedge clk_sys_i) begin
    if (got === 1'b1) begin
      e = q.pop_front();
      samples_checked++;
      if (rb !== e) begin
        fail_count++;
        $display("BAD t=%0t got %h exp %h", $time, rb, e);
      end
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    fail_count++;
    wrap_up();
  end
  initial begin
    seed = 32'h6548;
    {resetn_i, en, ev} = '0;
    ip = $random(seed);
    dp = $random(seed);
    repeat (12) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    chk(1'b0, 8'h84);
    sig(8'h01, 8'h84);
    for (int b = 3; b <= 6; b++) begin
      put(1'b0, 8'h1D);
      if (b == 3) put(1'b0, 8'h03);
      en = 6'($random(seed));
      pulse(b);
      sig({en[b-1], 7'h01}, 8'h80 | 8'(1 << b));
      chk(1'b0, 8'h80 | 8'(1 << b));
    end
    put(1'b0, 8'h1D);
    en = 6'h3F;
    msr_host_i.rd(1'b1, v, 1'b0);
    msr_host_i.wt();
    chk(1'b0, 8'h82);
    msr_host_i.wr(1'b0, 8'h0C);
    msr_host_i.wr(1'b0, 8'h1D);
    msr_host_i.wt();
    chk(1'b0, 8'h82);
    chk(1'b1, 8'h81);
    chk(1'b1, 8'h82);
    for (int k = 0; k < 2; k++) begin
      put(1'b0, k ? 8'h08 : 8'h09);
      for (int j = 3; j >= 0; j--)
        chk(1'b1, 8'((k ? dp : ip) >> (8 * j)));
    end
    put(1'b0, 8'h1D);
    foreach (mc[i]) begin
      put(1'b0, mc[i]);
      if (mc[i][4]) repeat (2) put(1'b1, 8'($random(seed)));
      sig(mh[i], 8'h80);
    end
    pulse(1);
    sig(8'h01, 8'h80);
    put(1'b0, 8'h1D);
    en = 6'h00;
    put(1'b0, 8'h1F);
    put(1'b1, 8'h18);
    put(1'b1, 8'h20);
    repeat (4) put(1'b1, 8'($random(seed)));
    sig(8'h41, 8'h80);
    put(1'b0, 8'h01);
    sig(8'h19, 8'h00);
    pulse(2);
    sig(8'h1D, 8'h04);
    put(1'b0, 8'h1F);
    put(1'b1, 8'h01);
    put(1'b1, 8'h00);
    chk(1'b0, 8'h04);
    put(1'b0, 8'h01);
    chk(1'b0, 8'h84);
    put(1'b0, 8'h06);
    put(1'b0, 8'h00);
    sig(8'h01, 8'h84);
    wrap_up();
  end
endmodule
